// ==== rtl/bic_exec.sv ====
// Executor for interrupt enable, jumps, increment and software trap
// ==========================================================
// What this block does
// - Interrupt-disable op clears global_int_enable in one cycle, no flags.
// - Interrupt-enable op sets global_int_enable in one cycle, no flags.
// - Direct jump: 9-bit immediate to PC[8:0], pc_high_buffer[1] to PC[9].
// - Direct jump is unconditional, flag-free, two cycles.
// - Computed jump loads table_high_pointer[1:0] and accumulator into PC.
// - Computed jump is unconditional, operand-free, flag-free, two cycles.
// - Increment adds one to R; destination bit picks accumulator or R.
// - Trap first pushes PC plus one onto the return stack.
// - Trap then loads PC with 001, no flags, three cycles total.
// - After a branch the fetched instruction is dropped, a NOP runs instead.
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module bic_exec
  import bic_pkg::*;
(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // Instruction issue
  input  wire logic              i_instr_valid,
  input  wire logic [2:0]        i_instr_op,
  input  wire logic [8:0]        i_instr_imm,
  input  wire logic [7:0]        i_reg_rdata,
  output logic                   o_instr_ready,
  // Register file write-back
  output logic                   o_reg_wr_en,
  output logic [5:0]             o_reg_wr_addr,
  output logic [7:0]             o_reg_wr_data,
  // Return stack
  output logic                   o_stack_push,
  output logic [BIC_PC_W-1:0]    o_stack_data,
  // Pipeline state
  output logic [BIC_PC_W-1:0]    o_pc,
  output logic                   o_flush,
  output logic                   o_global_int_enable,
  output logic                   o_zero_flag,
  // Avalon-MM slave
  input  wire logic [4:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest
);

  // ==========================================================
  // State
  // ==========================================================
  bic_state_e          state,            next_state;
  logic [BIC_PC_W-1:0] pc,               next_pc;
  logic                global_int_enable, next_global_int_enable;
  logic                zero_flag,        next_zero_flag;
  logic [7:0]          work_accumulator, next_work_accumulator;
  logic [1:0]          pc_high_buffer,   next_pc_high_buffer;
  logic [1:0]          table_high_pointer, next_table_high_pointer;
  logic                flush,            next_flush;
  logic                reg_wr_en,        next_reg_wr_en;
  logic [5:0]          reg_wr_addr,      next_reg_wr_addr;
  logic [7:0]          reg_wr_data,      next_reg_wr_data;
  logic                stack_push,       next_stack_push;
  logic [BIC_PC_W-1:0] stack_data,       next_stack_data;
  logic                bus_ack,          next_bus_ack;
  logic [31:0]         readdata,         next_readdata;
  logic                accept;
  logic [7:0]          inc_sum;
  logic                bus_wr;

  // Ready only in the execute state; trap and bubble stall issue
  assign o_instr_ready = (state == BIC_ST_EXEC);
  assign accept        = i_instr_valid && o_instr_ready;
  assign inc_sum       = i_reg_rdata + 8'h01;

  // One wait cycle per access; write lands at the releasing edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !bus_ack;
  assign bus_wr            = i_avs_write && bus_ack;

  // ==========================================================
  // Execution next-state logic
  // ==========================================================
  always_comb begin
    next_state              = state;
    next_pc                 = pc;
    next_global_int_enable  = global_int_enable;
    next_zero_flag          = zero_flag;
    next_work_accumulator   = work_accumulator;
    next_pc_high_buffer     = pc_high_buffer;
    next_table_high_pointer = table_high_pointer;
    next_flush              = 1'b0;
    next_reg_wr_en          = 1'b0;
    next_reg_wr_addr        = reg_wr_addr;
    next_reg_wr_data        = reg_wr_data;
    next_stack_push         = 1'b0;
    next_stack_data         = stack_data;
    // Software writes first so an executing op overrides them
    if (bus_wr) begin
      unique case (i_avs_address)
        BIC_REG_ACCUM:   next_work_accumulator   = i_avs_writedata[7:0];
        BIC_REG_PC_HIGH: next_pc_high_buffer     = i_avs_writedata[1:0];
        BIC_REG_TBLPTR:  next_table_high_pointer = i_avs_writedata[1:0];
        default:         next_pc_high_buffer     = pc_high_buffer;
      endcase
    end
    unique case (state)
      BIC_ST_EXEC: begin
        if (accept) begin
          next_pc = pc + BIC_PC_STEP;
          unique case (i_instr_op)
            BIC_OP_INT_DIS: next_global_int_enable = 1'b0;
            BIC_OP_INT_EN:  next_global_int_enable = 1'b1;
            BIC_OP_JMP_DIR: begin
              next_pc    = {pc_high_buffer[1], i_instr_imm};
              next_flush = 1'b1;
              next_state = BIC_ST_BUBBLE;
            end
            BIC_OP_JMP_COMP: begin
              next_pc    = {table_high_pointer, work_accumulator};
              next_flush = 1'b1;
              next_state = BIC_ST_BUBBLE;
            end
            BIC_OP_INC: begin
              // zero flag from wrapped 8-bit sum
              next_zero_flag = (inc_sum == 8'h00);
              if (i_instr_imm[BIC_DEST_BIT]) begin
                next_reg_wr_en   = 1'b1;
                next_reg_wr_addr = i_instr_imm[BIC_REG_MSB:0];
                next_reg_wr_data = inc_sum;
              end else begin
                next_work_accumulator = inc_sum;
              end
            end
            BIC_OP_TRAP: begin
              next_stack_push = 1'b1;
              next_stack_data = pc + BIC_PC_STEP;
              next_pc         = pc;
              next_state      = BIC_ST_TRAP;
            end
            default: next_pc = pc + BIC_PC_STEP;
          endcase
        end
      end
      BIC_ST_TRAP: begin
        next_pc    = BIC_TRAP_VECTOR;
        next_flush = 1'b1;
        next_state = BIC_ST_BUBBLE;
      end
      BIC_ST_BUBBLE: begin
        // fetched word dropped, this cycle is the NOP
        next_state = BIC_ST_EXEC;
      end
    endcase
  end

  // ==========================================================
  // Bus read path, captured during the wait cycle
  // ==========================================================
  always_comb begin
    next_bus_ack  = (i_avs_read || i_avs_write) && !bus_ack;
    next_readdata = 32'h00000000;
    if (i_avs_read) begin
      unique case (i_avs_address)
        BIC_REG_STATUS: begin
          next_readdata[BIC_STAT_IE_BIT] = global_int_enable;
          next_readdata[BIC_STAT_Z_BIT]  = zero_flag;
        end
        BIC_REG_ACCUM:   next_readdata[7:0] = work_accumulator;
        BIC_REG_PC_HIGH: next_readdata[1:0] = pc_high_buffer;
        BIC_REG_TBLPTR:  next_readdata[1:0] = table_high_pointer;
        BIC_REG_PC:      next_readdata[BIC_PC_W-1:0] = pc;
        default:         next_readdata = 32'h00000000; // Unmapped
      endcase
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state              <= BIC_ST_EXEC;
      pc                 <= BIC_PC_RESET;
      global_int_enable  <= BIC_GIE_RESET;
      zero_flag          <= 1'b0;
      work_accumulator   <= BIC_ACC_RESET;
      pc_high_buffer     <= BIC_HI_RESET;
      table_high_pointer <= BIC_HI_RESET;
      flush              <= 1'b0;
      reg_wr_en          <= 1'b0;
      reg_wr_addr        <= 6'h00;
      reg_wr_data        <= 8'h00;
      stack_push         <= 1'b0;
      stack_data         <= BIC_PC_RESET;
      bus_ack            <= 1'b0;
      readdata           <= 32'h00000000;
    end else begin
      state              <= next_state;
      pc                 <= next_pc;
      global_int_enable  <= next_global_int_enable;
      zero_flag          <= next_zero_flag;
      work_accumulator   <= next_work_accumulator;
      pc_high_buffer     <= next_pc_high_buffer;
      table_high_pointer <= next_table_high_pointer;
      flush              <= next_flush;
      reg_wr_en          <= next_reg_wr_en;
      reg_wr_addr        <= next_reg_wr_addr;
      reg_wr_data        <= next_reg_wr_data;
      stack_push         <= next_stack_push;
      stack_data         <= next_stack_data;
      bus_ack            <= next_bus_ack;
      readdata           <= next_readdata;
    end
  end

  // Outputs straight from flops
  assign o_pc                = pc;
  assign o_flush             = flush;
  assign o_global_int_enable = global_int_enable;
  assign o_zero_flag         = zero_flag;
  assign o_reg_wr_en         = reg_wr_en;
  assign o_reg_wr_addr       = reg_wr_addr;
  assign o_reg_wr_data       = reg_wr_data;
  assign o_stack_push        = stack_push;
  assign o_stack_data        = stack_data;
  assign o_avs_readdata      = readdata;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  logic [BIC_PC_W-1:0] jmp_dir_target;
  logic [BIC_PC_W-1:0] jmp_comp_target;
  assign jmp_dir_target  = {pc_high_buffer[1], i_instr_imm};
  assign jmp_comp_target = {table_high_pointer, work_accumulator};

  chk_disable_clears: assert property (
    accept && i_instr_op == BIC_OP_INT_DIS |=> !o_global_int_enable
  ) else $error("interrupt enable not cleared");

  chk_enable_sets: assert property (
    accept && i_instr_op == BIC_OP_INT_EN |=> o_global_int_enable
  ) else $error("interrupt enable not set");

  chk_direct_target: assert property (
    accept && i_instr_op == BIC_OP_JMP_DIR |=> o_pc == $past(jmp_dir_target)
  ) else $error("direct jump target wrong");

  chk_jump_two_cycles: assert property (
    accept && (i_instr_op == BIC_OP_JMP_DIR || i_instr_op == BIC_OP_JMP_COMP)
    |=> !o_instr_ready && o_flush && $stable(o_zero_flag) ##1 o_instr_ready
  ) else $error("jump not two cycles");

  chk_computed_target: assert property (
    accept && i_instr_op == BIC_OP_JMP_COMP
    |=> o_pc == $past(jmp_comp_target)
  ) else $error("computed jump target wrong");

  chk_inc_dest_reg: assert property (
    accept && i_instr_op == BIC_OP_INC && i_instr_imm[BIC_DEST_BIT]
    |=> o_reg_wr_en && o_reg_wr_data == $past(i_reg_rdata) + 8'h01
  ) else $error("increment write-back wrong");

  chk_inc_zero: assert property (
    accept && i_instr_op == BIC_OP_INC
    |=> o_zero_flag == ($past(i_reg_rdata) == 8'hFF) && o_instr_ready
  ) else $error("increment zero flag wrong");

  chk_trap_push: assert property (
    accept && i_instr_op == BIC_OP_TRAP
    |=> o_stack_push && o_stack_data == $past(o_pc) + BIC_PC_STEP
  ) else $error("trap push wrong");

  chk_trap_vector: assert property (
    accept && i_instr_op == BIC_OP_TRAP |=> !o_instr_ready
    ##1 (o_pc == BIC_TRAP_VECTOR && o_flush && !o_instr_ready)
    ##1 o_instr_ready
  ) else $error("trap sequence wrong");

  chk_flush_bubble: assert property (
    o_flush |-> !o_instr_ready ##1 o_instr_ready
  ) else $error("flush without bubble");

  chk_trap_keeps_enable: assert property (
    accept && i_instr_op == BIC_OP_TRAP && !bus_wr
    |=> $stable(o_global_int_enable) [*2]
  ) else $error("trap touched interrupt enable");

  cov_direct_jump: cover property (accept && i_instr_op == BIC_OP_JMP_DIR);
  cov_trap_seq:    cover property (accept && i_instr_op == BIC_OP_TRAP
                                   ##3 o_instr_ready);
  cov_inc_wrap:    cover property (accept && i_instr_op == BIC_OP_INC
                                   && i_reg_rdata == 8'hFF);
  cov_trap_masked: cover property (accept && i_instr_op == BIC_OP_TRAP
                                   && !o_global_int_enable);

endmodule

// ==== rtl/bic_pkg.sv ====
// Constants and types shared by the branch / interrupt-control executor
package bic_pkg;

  // ==========================================================
  // Operation codes on the issue port
  // ==========================================================
  localparam logic [2:0] BIC_OP_NOP       = 3'h0;
  localparam logic [2:0] BIC_OP_INT_DIS   = 3'h1;
  localparam logic [2:0] BIC_OP_INT_EN    = 3'h2;
  localparam logic [2:0] BIC_OP_JMP_DIR   = 3'h3;
  localparam logic [2:0] BIC_OP_JMP_COMP  = 3'h4;
  localparam logic [2:0] BIC_OP_INC       = 3'h5;
  localparam logic [2:0] BIC_OP_TRAP      = 3'h6;

  // ==========================================================
  // Operand field layout for the increment
  // ==========================================================
  localparam int         BIC_DEST_BIT     = 6;
  localparam int         BIC_REG_MSB      = 5;

  // ==========================================================
  // Program counter constants
  // ==========================================================
  localparam int         BIC_PC_W         = 10;
  localparam logic [9:0] BIC_PC_RESET     = 10'h000;
  localparam logic [9:0] BIC_TRAP_VECTOR  = 10'h001;
  localparam logic [9:0] BIC_PC_STEP      = 10'h001;

  // ==========================================================
  // Register map, byte addresses on the Avalon port
  // ==========================================================
  localparam logic [4:0] BIC_REG_STATUS   = 5'h00;
  localparam logic [4:0] BIC_REG_ACCUM    = 5'h04;
  localparam logic [4:0] BIC_REG_PC_HIGH  = 5'h08;
  localparam logic [4:0] BIC_REG_TBLPTR   = 5'h0C;
  localparam logic [4:0] BIC_REG_PC       = 5'h10;
  localparam int         BIC_STAT_IE_BIT  = 0;
  localparam int         BIC_STAT_Z_BIT   = 1;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic       BIC_GIE_RESET    = 1'b0;
  localparam logic [7:0] BIC_ACC_RESET    = 8'h00;
  localparam logic [1:0] BIC_HI_RESET     = 2'h0;

  // ==========================================================
  // Executor states, one-hot
  // ==========================================================
  typedef enum logic [2:0] {
    BIC_ST_EXEC   = 3'b001,
    BIC_ST_TRAP   = 3'b010,
    BIC_ST_BUBBLE = 3'b100
  } bic_state_e;

endpackage

// ==== tb/tb_bic_exec.sv ====
// Self-checking testbench for the branch and interrupt-control executor
`timescale 1ns/1ps
module tb_bic_exec;
  import bic_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic        i_core_clk;
  logic        i_rst;
  logic        i_instr_valid;
  logic [2:0]  i_instr_op;
  logic [8:0]  i_instr_imm;
  logic [7:0]  i_reg_rdata;
  logic [4:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic        o_instr_ready;
  logic        o_reg_wr_en;
  logic [5:0]  o_reg_wr_addr;
  logic [7:0]  o_reg_wr_data;
  logic        o_stack_push;
  logic [9:0]  o_stack_data;
  logic [9:0]  o_pc;
  logic        o_flush;
  logic        o_global_int_enable;
  logic        o_zero_flag;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  int          errors;
  int          tests_run;
  int          cycles;
  logic [31:0] rd;
  logic [2:0]  ops [4] = '{BIC_OP_INT_EN, BIC_OP_NOP, BIC_OP_INT_DIS, 3'h7};
  logic        enables [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  bic_exec i_bic_exec (
    .i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_instr_valid(i_instr_valid), .i_instr_op(i_instr_op),
    .i_instr_imm(i_instr_imm), .i_reg_rdata(i_reg_rdata),
    .o_instr_ready(o_instr_ready), .o_reg_wr_en(o_reg_wr_en),
    .o_reg_wr_addr(o_reg_wr_addr), .o_reg_wr_data(o_reg_wr_data),
    .o_stack_push(o_stack_push), .o_stack_data(o_stack_data),
    .o_pc(o_pc), .o_flush(o_flush),
    .o_global_int_enable(o_global_int_enable), .o_zero_flag(o_zero_flag),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest)
  );

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Whole run is about 75 cycles, so 2000 means a hang
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      $display("BAD t=%0t timeout", $time);
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Avalon access; request held until waitrequest is sampled low at an edge
  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] wd);
    @(posedge i_core_clk);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    i_avs_writedata <= wd;
    // No cycle count assumed; only the hang guard ends a stuck wait
    do begin
      @(posedge i_core_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp,
                        input string what);
    av(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // Offers one op and returns at the edge that takes it; valid stays up
  task automatic issue(input logic [2:0] op, input logic [8:0] imm,
                       input logic [7:0] rv);
    i_instr_valid <= 1'b1;
    i_instr_op    <= op;
    i_instr_imm   <= imm;
    i_reg_rdata   <= rv;
    do begin
      @(posedge i_core_clk);
    end while (o_instr_ready !== 1'b1);
  endtask

  // Withdraw the offer and look at the cycle after the taking edge
  task automatic settle();
    i_instr_valid <= 1'b0;
    @(negedge i_core_clk);
  endtask

  task automatic jump(input logic [2:0] op, input logic [8:0] imm,
                      input logic [9:0] pc);
    issue(op, imm, 8'h00);
    settle();
    chk(32'(o_pc), 32'(pc), "jump target");
    chk(32'(o_flush), 32'h1, "bubble flush");
    chk(32'(o_instr_ready), 32'h0, "ready during bubble");
    @(negedge i_core_clk);
    chk(32'(o_flush), 32'h0, "flush one cycle");
    chk(32'(o_instr_ready), 32'h1, "ready after two cycles");
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    i_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr_op = BIC_OP_NOP;
    i_instr_imm = 9'h000;
    i_reg_rdata = 8'h00;
    i_avs_address = 5'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // Register map reset values and an unmapped word
    rd_chk(BIC_REG_STATUS, 32'h0, "status reset");
    rd_chk(BIC_REG_ACCUM, 32'h0, "accumulator reset");
    rd_chk(BIC_REG_PC_HIGH, 32'h0, "pc high buffer reset");
    rd_chk(BIC_REG_TBLPTR, 32'h0, "table pointer reset");
    rd_chk(BIC_REG_PC, 32'h0, "pc reset");
    rd_chk(5'h14, 32'h0, "unmapped reads zero");
    // One-cycle ops, including the spare code, step the pc
    for (int k = 0; k < 4; k++) begin
      issue(ops[k], 9'h000, 8'h00);
      settle();
      chk(32'(o_global_int_enable), 32'(enables[k]), "enable");
      chk(32'(o_pc), 32'(k + 1), "single cycle op");
      chk(32'(o_zero_flag), 32'h0, "flags untouched");
      @(posedge i_core_clk);
    end
    // Increment to R wraps FF to 00 and sets zero
    issue(BIC_OP_INC, 9'h07F, 8'hFF);
    settle();
    chk(32'(o_reg_wr_en), 32'h1, "write back to R");
    chk(32'(o_reg_wr_addr), 32'h3F, "R address 63");
    chk(32'(o_reg_wr_data), 32'h0, "wrapped sum");
    chk(32'(o_zero_flag), 32'h1, "zero set");
    // Back-to-back increments, to accumulator then to R
    @(posedge i_core_clk);
    issue(BIC_OP_INC, 9'h001, 8'h33);
    issue(BIC_OP_INC, 9'h042, 8'hFF);
    settle();
    chk(32'(o_pc), 32'h7, "increments one cycle each");
    chk(32'(o_reg_wr_addr), 32'h02, "second target R");
    chk(32'(o_zero_flag), 32'h1, "zero from last sum");
    rd_chk(BIC_REG_ACCUM, 32'h34, "sum into accumulator");
    // Trap with interrupts masked: push, vector, three cycles
    issue(BIC_OP_TRAP, 9'h000, 8'h00);
    settle();
    chk(32'(o_stack_push), 32'h1, "return push");
    chk(32'(o_stack_data), 32'h8, "return address");
    chk(32'(o_instr_ready), 32'h0, "trap busy");
    chk(32'(o_global_int_enable), 32'h0, "enable kept");
    @(negedge i_core_clk);
    chk(32'(o_stack_push), 32'h0, "single push");
    chk(32'(o_pc), 32'(BIC_TRAP_VECTOR), "trap vector");
    chk(32'(o_flush), 32'h1, "trap bubble");
    chk(32'(o_instr_ready), 32'h0, "trap still busy");
    @(negedge i_core_clk);
    chk(32'(o_instr_ready), 32'h1, "trap done");
    // Direct jumps take only bit 1 of the high buffer
    av(1'b1, BIC_REG_PC_HIGH, 32'h2);
    jump(BIC_OP_JMP_DIR, 9'h1A5, 10'h3A5);
    av(1'b1, BIC_REG_PC_HIGH, 32'h1);
    jump(BIC_OP_JMP_DIR, 9'h1FF, 10'h1FF);
    // Computed jump ignores the immediate field
    av(1'b1, BIC_REG_TBLPTR, 32'h2);
    jump(BIC_OP_JMP_COMP, 9'h1FF, 10'h234);
    // Flags survive jumps and trap; status is read only
    rd_chk(BIC_REG_STATUS, 32'h2, "flags kept");
    av(1'b1, BIC_REG_STATUS, 32'h1);
    rd_chk(BIC_REG_STATUS, 32'h2, "status read only");
    av(1'b1, 5'h14, 32'hFF);
    rd_chk(5'h14, 32'h0, "unmapped write ignored");
    rd_chk(BIC_REG_PC_HIGH, 32'h1, "pc high buffer readback");
    summarize();
  end

endmodule
